// File: rtl/cqt_pkg.sv
// Purpose: Constants for the query table read-out block.
// Assumes: 16-bit data bus, word addressing.
// Notes: Table contents are the identification, system-interface and geometry bytes.
package cqt_pkg;
  localparam int          DATA_W           = 16;
  localparam int          ADDR_W           = 24;
  localparam logic [7:0]  HIGH_BYTE_FILL   = 8'h00;
  localparam logic [7:0]  UNUSED_BYTE      = 8'h00;
  localparam logic [23:0] TABLE_BASE       = 24'h000010;
  localparam logic [23:0] SYSIF_BASE       = 24'h00001b;
  localparam logic [23:0] GEOM_BASE        = 24'h000027;
  localparam logic [23:0] EXT_PTR_ADDR     = 24'h000015;
  localparam logic [23:0] ROM_LAST         = 24'h00002b;
  localparam logic [7:0]  ID_Q             = 8'h51;
  localparam logic [7:0]  ID_R             = 8'h52;
  localparam logic [7:0]  ID_Y             = 8'h59;
  localparam logic [15:0] PRIMARY_CMD_SET  = 16'h0001;
  localparam logic [15:0] EXT_TABLE_ADDR   = 16'h010a;
  localparam logic [15:0] ALTERNATE_CMD_SET = 16'h0000;
  localparam logic [15:0] ALT_TABLE_ADDR   = 16'h0000;
  localparam logic [7:0]  DEVICE_SIZE_LOG2 = 8'h17;
endpackage : cqt_pkg

// File: rtl/cqt_rom.sv
// Purpose: Combinational lookup of one query table byte by word address.
// Assumes: Address is a word address.
// Notes: Multi-byte fields are stored low byte first.
`timescale 1ns/1ps
module cqt_rom
  import cqt_pkg::*;
(
  // Lookup
  input  wire logic [ADDR_W-1:0] addr,
  output logic      [7:0]        data
);
  always_comb begin
    data = UNUSED_BYTE;
    unique case (addr)
      TABLE_BASE:                data = ID_Q;
      TABLE_BASE + 24'h000001:   data = ID_R;
      TABLE_BASE + 24'h000002:   data = ID_Y;
      24'h000013:                data = PRIMARY_CMD_SET[7:0];
      24'h000014:                data = PRIMARY_CMD_SET[15:8];
      EXT_PTR_ADDR:              data = EXT_TABLE_ADDR[7:0];
      EXT_PTR_ADDR + 24'h000001: data = EXT_TABLE_ADDR[15:8];
      24'h000017:                data = ALTERNATE_CMD_SET[7:0];
      24'h000018:                data = ALTERNATE_CMD_SET[15:8];
      24'h000019:                data = ALT_TABLE_ADDR[7:0];
      24'h00001a:                data = ALT_TABLE_ADDR[15:8];
      SYSIF_BASE:                data = 8'h17;
      24'h00001c:                data = 8'h20;
      24'h00001d:                data = 8'h85;
      24'h00001e:                data = 8'h95;
      24'h00001f:                data = 8'h08;
      24'h000020:                data = 8'h09;
      24'h000021:                data = 8'h0a;
      24'h000022:                data = 8'h00;
      24'h000023:                data = 8'h01;
      24'h000024:                data = 8'h01;
      24'h000025:                data = 8'h02;
      24'h000026:                data = 8'h00;
      GEOM_BASE:                 data = DEVICE_SIZE_LOG2;
      24'h000028:                data = 8'h01;
      24'h000029:                data = 8'h00;
      24'h00002a:                data = 8'h06;
      24'h00002b:                data = 8'h00;
      default:                   data = UNUSED_BYTE;
    endcase
  end
endmodule : cqt_rom

// File: rtl/cqt_readout.sv
// Purpose: Read path mux that serves the query table while query mode is on.
// Assumes: Host strobes rd_req with a word address; data returns one cycle later.
// Notes: query_enter and query_exit come from the command decoder.
// Notes on behaviour
// - Query mode reads return table, not array.
// - Table byte on low lane, high zero.
// - Offsets are word addresses, table at 10h.
// - Words 10h-12h return 51, 52, 59.
// - Multi-byte fields stored low byte first.
// - Vendor 0-Fh, id 10h, sysif 1Bh, geometry 27h.
// - Offset 15 holds extended table address.
// - Extended table pointer reads 0A then 01.
`timescale 1ns/1ps
module cqt_readout
  import cqt_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Mode control
  input  wire logic              query_enter,
  input  wire logic              query_exit,
  // Host read
  input  wire logic              rd_req,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_valid,
  // Array
  output logic      [ADDR_W-1:0] array_addr,
  input  wire logic [DATA_W-1:0] array_data,
  // Status
  output logic                   query_mode
);
  logic              query_ff;
  logic [DATA_W-1:0] data_ff;
  logic              valid_ff;
  logic [7:0]        table_byte;

  // Exit takes priority so a stray enter during exit leaves array reads.
  always_ff @(posedge clk) begin
    if (rst) begin
      query_ff <= 1'b0;
    end else if (query_exit) begin
      query_ff <= 1'b0;
    end else if (query_enter) begin
      query_ff <= 1'b1;
    end
  end

  cqt_rom u_rom (
    .addr (rd_addr),
    .data (table_byte)
  );

  assign array_addr = rd_addr;

  always_ff @(posedge clk) begin
    if (rst) begin
      data_ff <= '0;
    end else if (rd_req) begin
      if (query_ff) begin
        data_ff <= {HIGH_BYTE_FILL, table_byte};
      end else begin
        data_ff <= array_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= rd_req;
    end
  end

  assign rd_data    = data_ff;
  assign rd_valid   = valid_ff;
  assign query_mode = query_ff;

  property p_high_zero;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff) |=> (rd_data[15:8] == HIGH_BYTE_FILL);
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("high byte not zero");

  property p_id_q;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == TABLE_BASE) |=> (rd_data == 16'h0051);
  endproperty
  a_id_q: assert property (p_id_q) else $error("Q byte wrong");

  property p_id_y;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == 24'h000012) |=> (rd_data == 16'h0059);
  endproperty
  a_id_y: assert property (p_id_y) else $error("Y byte wrong");

  property p_ext_lo;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == EXT_PTR_ADDR) |=> (rd_data == 16'h000a);
  endproperty
  a_ext_lo: assert property (p_ext_lo) else $error("pointer low wrong");

  property p_ext_hi;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == 24'h000016) |=> (rd_data == 16'h0001);
  endproperty
  a_ext_hi: assert property (p_ext_hi) else $error("pointer high wrong");

  property p_array;
    @(posedge clk) disable iff (rst)
      (rd_req && !query_ff) |=> (rd_data == $past(array_data));
  endproperty
  a_array: assert property (p_array) else $error("array data lost");

  property p_exit;
    @(posedge clk) disable iff (rst)
      query_exit |=> !query_mode;
  endproperty
  a_exit: assert property (p_exit) else $error("mode not left");

  property p_sysif;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == SYSIF_BASE) |=> (rd_data == 16'h0017);
  endproperty
  a_sysif: assert property (p_sysif) else $error("sysif byte wrong");

  // Read handshake, hold and mode checks.
  property p_valid_rise;
    @(posedge clk) disable iff (rst)
      rd_req |=> rd_valid;
  endproperty
  a_valid_rise: assert property (p_valid_rise) else $error("read not answered");

  property p_valid_fall;
    @(posedge clk) disable iff (rst)
      !rd_req |=> !rd_valid;
  endproperty
  a_valid_fall: assert property (p_valid_fall) else $error("valid without request");

  property p_data_hold;
    @(posedge clk) disable iff (rst)
      !rd_req |=> $stable(rd_data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved");

  property p_reset_state;
    @(posedge clk)
      rst |=> (!rd_valid && !query_mode && (rd_data == '0));
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_enter;
    @(posedge clk) disable iff (rst)
      (query_enter && !query_exit) |=> query_mode;
  endproperty
  a_enter: assert property (p_enter) else $error("mode not entered");

  property p_mode_hold;
    @(posedge clk) disable iff (rst)
      (!query_enter && !query_exit) |=> $stable(query_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed unasked");

  // Table content checks; expected words are spelled out, except the geometry word built from DEVICE_SIZE_LOG2.
  property p_id_r;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == 24'h000011) |=> (rd_data == 16'h0052);
  endproperty
  a_id_r: assert property (p_id_r) else $error("R byte wrong");

  property p_cmd_lo;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == 24'h000013) |=> (rd_data == 16'h0001);
  endproperty
  a_cmd_lo: assert property (p_cmd_lo) else $error("command set low wrong");

  property p_cmd_hi;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == 24'h000014) |=> (rd_data == 16'h0000);
  endproperty
  a_cmd_hi: assert property (p_cmd_hi) else $error("command set high wrong");

  property p_alt_zero;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr inside {[24'h000017:24'h00001a]}) |=>
        (rd_data == 16'h0000);
  endproperty
  a_alt_zero: assert property (p_alt_zero) else $error("alternate field not zero");

  property p_vendor_zero;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr < TABLE_BASE) |=> (rd_data == 16'h0000);
  endproperty
  a_vendor_zero: assert property (p_vendor_zero) else $error("vendor area not zero");

  property p_vcc_max;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == 24'h00001c) |=> (rd_data == 16'h0020);
  endproperty
  a_vcc_max: assert property (p_vcc_max) else $error("supply max byte wrong");

  property p_vpp_min;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == 24'h00001d) |=> (rd_data == 16'h0085);
  endproperty
  a_vpp_min: assert property (p_vpp_min) else $error("program supply byte wrong");

  property p_geom;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == GEOM_BASE) |=>
        (rd_data == {HIGH_BYTE_FILL, DEVICE_SIZE_LOG2});
  endproperty
  a_geom: assert property (p_geom) else $error("device size byte wrong");

  property p_iface_lo;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == 24'h000028) |=> (rd_data == 16'h0001);
  endproperty
  a_iface_lo: assert property (p_iface_lo) else $error("interface code low wrong");

  property p_buf;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr == 24'h00002a) |=> (rd_data == 16'h0006);
  endproperty
  a_buf: assert property (p_buf) else $error("write buffer byte wrong");

  property p_past_end;
    @(posedge clk) disable iff (rst)
      (rd_req && query_ff && rd_addr > ROM_LAST) |=> (rd_data == 16'h0000);
  endproperty
  a_past_end: assert property (p_past_end) else $error("read past table not zero");
endmodule : cqt_readout

// File: bench/cqt_array_model.sv
// Purpose: Stand-in for the storage array behind the read path.
// Assumes: Combinational array read by word address.
// Notes: Each word's high byte differs from 00 except where the address low byte
// is A5h, so an array word that leaks into a query-mode read shows up.
`timescale 1ns/1ps
module cqt_array_model
  import cqt_pkg::*;
(
  // Array
  input  wire logic [ADDR_W-1:0] array_addr,
  output logic      [DATA_W-1:0] array_data
);
  assign array_data = {array_addr[7:0] ^ 8'ha5, array_addr[7:0]};
endmodule : cqt_array_model

// File: bench/testbench.sv
// Purpose: Self-checking bench for the query table read-out.
// Assumes: Read answer one cycle after the request.
// Notes: Inputs change on the falling edge.
`timescale 1ns/1ps
module testbench;
  import cqt_pkg::*;
  logic              clk, rst, query_enter, query_exit, rd_req, rd_valid, query_mode;
  logic [ADDR_W-1:0] rd_addr, array_addr;
  logic [DATA_W-1:0] rd_data, array_data;
  int                n_mismatch = 0;
  int                n_tests = 0;
  logic [7:0]        tbl [13] = '{8'h00, 8'h51, 8'h52, 8'h59, 8'h01, 8'h00, 8'h0a,
                                  8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h17};

  cqt_readout dut_u (.clk(clk), .rst(rst), .query_enter(query_enter),
    .query_exit(query_exit), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .array_addr(array_addr), .array_data(array_data),
    .query_mode(query_mode));
  cqt_array_model arr_u (.array_addr(array_addr), .array_data(array_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task check(string what, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Leaves rd_req high so reads can run back to back.
  task rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge clk);
    check("rd_valid", {15'h0000, rd_valid}, 16'h0001);
    check("rd_data", rd_data, exp);
  endtask : rd

  task t_array;
    rd(24'h000010, 16'hb510);
    rd_req = 1'b0;
    @(negedge clk);
    check("rd_valid", {15'h0000, rd_valid}, 16'h0000);
    check("rd_data", rd_data, 16'hb510);
  endtask : t_array

  task t_query;
    query_enter = 1'b1;
    @(negedge clk);
    query_enter = 1'b0;
    check("query_mode", {15'h0000, query_mode}, 16'h0001);
    for (int i = 0; i < 13; i++) begin
      rd(24'h00000f + i, {8'h00, tbl[i]});
    end
    rd(24'h00001c, 16'h0020);
    rd(24'h00001d, 16'h0085);
    rd(24'h000027, {8'h00, DEVICE_SIZE_LOG2});
    rd(24'h000028, 16'h0001);
    rd(24'h00002a, 16'h0006);
    rd(24'h000001, 16'h0000);
    rd(24'h00002c, 16'h0000);
    rd_req = 1'b0;
  endtask : t_query

  task t_exit;
    query_exit = 1'b1;
    @(negedge clk);
    query_exit = 1'b0;
    check("query_mode", {15'h0000, query_mode}, 16'h0000);
    rd(24'h000015, 16'hb015);
    rd_req = 1'b0;
  endtask : t_exit

  task t_idle;
    check("rd_data", rd_data, 16'h0000);
    check("rd_valid", {15'h0000, rd_valid}, 16'h0000);
    check("query_mode", {15'h0000, query_mode}, 16'h0000);
  endtask : t_idle

  // Enter, then exit with enter still high: exit must win.
  task t_both;
    query_enter = 1'b1;
    @(negedge clk);
    query_exit = 1'b1;
    check("query_mode", {15'h0000, query_mode}, 16'h0001);
    @(negedge clk);
    query_enter = 1'b0;
    query_exit = 1'b0;
    check("query_mode", {15'h0000, query_mode}, 16'h0000);
    rd(24'h000010, 16'hb510);
    rd_req = 1'b0;
  endtask : t_both

  // Reset in mid-run while in query mode must fall back to array reads.
  task t_midreset;
    query_enter = 1'b1;
    @(negedge clk);
    query_enter = 1'b0;
    rd(24'h000011, 16'h0052);
    rd_req = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_idle();
    rd(24'h000011, 16'hb411);
    rd_req = 1'b0;
  endtask : t_midreset

  task close_out;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  initial begin
    rst = 1'b1;
    query_enter = 1'b0;
    query_exit = 1'b0;
    rd_req = 1'b0;
    rd_addr = 24'h000000;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_idle();
    t_array();
    t_query();
    t_exit();
    t_both();
    t_midreset();
    close_out();
  end

  initial begin
    #2000;
    n_mismatch++;
    close_out();
  end
endmodule : testbench
